// ===== rtl/tcr_pkg.sv
package tcr_pkg;
    // --------------------------------------------------------------
    // register indices (byte address is not used: plain port)
    // --------------------------------------------------------------
    localparam logic [2:0] ADDR_INTERRUPT_EDGE_DELAY_ONE = 3'h2;
    localparam logic [2:0] ADDR_TIMEOUT_DELAY_TWO        = 3'h3;
    localparam logic [2:0] ADDR_DELAY_THREE              = 3'h4;
    localparam logic [2:0] ADDR_FIRE_PULSE_CONFIG        = 3'h5;

    // --------------------------------------------------------------
    // reset values
    // --------------------------------------------------------------
    localparam logic [31:0] RST_REG2 = 32'h2000_0000;
    localparam logic [31:0] RST_REG3 = 32'h1800_0000;
    localparam logic [31:0] RST_REG4 = 32'h2000_0000;
    localparam logic [31:0] RST_REG5 = 32'h0000_0000;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int INT_TIMEOUT_BIT  = 31;
    localparam int INT_ENDHITS_BIT  = 30;
    localparam int INT_ALU_BIT      = 29;
    localparam int CH2_EDGE_BIT     = 28;
    localparam int CH1_EDGE_BIT     = 27;
    localparam int ERR_FILL_BIT     = 31;
    localparam int PRESCALE_HI      = 30;
    localparam int PRESCALE_LO      = 29;
    localparam int DELAY_HI         = 26;
    localparam int DELAY_LO         = 8;
    localparam int CFG_HI           = 31;
    localparam int CFG_LO           = 29;
    localparam int START_JIT_BIT    = 28;
    localparam int PHASE_OFF_BIT    = 27;
    localparam int REPEAT_HI        = 26;
    localparam int REPEAT_LO        = 24;
    localparam int INVERT_HI        = 23;
    localparam int INVERT_LO        = 8;
    localparam int TAG_HI           = 7;
    localparam int TAG_LO           = 0;

    localparam int DELAY_W   = 19;
    localparam int INVERT_W  = 15;

    localparam logic [31:0] TIMEOUT_FILL_VALUE = 32'h0FFF_FFFF;

    // --------------------------------------------------------------
    // timeout predivider figures (us at a 4 MHz fast clock)
    // --------------------------------------------------------------
    localparam int FAST_CLK_MHZ     = 4;
    localparam int TIMEOUT_US_0     = 64;
    localparam int TIMEOUT_US_1     = 256;
    localparam int TIMEOUT_US_2     = 1024;
    localparam int TIMEOUT_US_3     = 4096;
    localparam logic [14:0] TIMEOUT_CYC_0 = 15'(TIMEOUT_US_0 * FAST_CLK_MHZ);
    localparam logic [14:0] TIMEOUT_CYC_1 = 15'(TIMEOUT_US_1 * FAST_CLK_MHZ);
    localparam logic [14:0] TIMEOUT_CYC_2 = 15'(TIMEOUT_US_2 * FAST_CLK_MHZ);
    localparam logic [14:0] TIMEOUT_CYC_3 = 15'(TIMEOUT_US_3 * FAST_CLK_MHZ);
endpackage

// ===== rtl/tcr_config_regs.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps

// Functional notes
// - timeout, end-hits, ALU interrupt enables at bits 31..29, ORed to one
// - external memory-done source enable from the memDoneIrqEn input ORed in
// - channel 2 edge bit set: both edges count, else one edge
// - channel 1 edge bit set: both edges count, else one edge
// - hit 1 stop window: unsigned 14.5 fixed point, reference periods
// - hit 2 stop window: same 19-bit fixed point format
// - hit 3 stop window: same 14.5 fixed point format
// - error fill on timeout makes result all-ones value hFFFFFFF
// - 2-bit timeout prescale code selects 64/256/1024/4096 us
// - bit31 invert downstream, bit30 enable up, bit29 enable down
// - start jitter bit switches on noise for the start channel
// - phase jitter off bit disables phase noise unit when set
// - fire sequence repeats 0 to 7 times per 3-bit field
// - per-pulse invert bit for up to 15 pulses, 1 = low-high jump
// - low 8 bits of each register are free tag storage
// - analog enable 0 selects digital stops, 1 selects analog mux
module tcr_config_regs
    import tcr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [31:0] regRdata,
    input  wire logic        irqTimeout,
    input  wire logic        irqEndHits,
    input  wire logic        irqAlu,
    input  wire logic        irqMemDone,
    input  wire logic        memDoneIrqEn,
    input  wire logic        analogEnable,
    output logic             irqOut,
    output logic             ch1BothEdges,
    output logic             ch2BothEdges,
    output logic             stopAnalogSel,
    output logic [18:0]      stopWindowHit1,
    output logic [18:0]      stopWindowHit2,
    output logic [18:0]      stopWindowHit3,
    output logic             timeoutErrorFill,
    output logic [31:0]      timeoutFillValue,
    output logic [14:0]      timeoutCycles,
    output logic             fireUpEnable,
    output logic             fireDownEnable,
    output logic             fireDownInvert,
    output logic             startJitterOn,
    output logic             phaseJitterOn,
    output logic [2:0]       repeatCount,
    output logic [14:0]      perPulseInvert
);

    // --------------------------------------------------------------
    // register storage
    // --------------------------------------------------------------
    logic [31:0] reg2_r;
    logic [31:0] reg3_r;
    logic [31:0] reg4_r;
    logic [31:0] reg5_r;
    logic [31:0] regRdata_r;

    logic        irqOut_r;
    logic        ch1Edge_r;
    logic        ch2Edge_r;
    logic        analogSel_r;
    logic [18:0] win1_r;
    logic [18:0] win2_r;
    logic [18:0] win3_r;
    logic        errFill_r;
    logic [31:0] fillVal_r;
    logic [14:0] toCyc_r;
    logic        fireUp_r;
    logic        fireDown_r;
    logic        fireInv_r;
    logic        startJit_r;
    logic        phaseJit_r;
    logic [2:0]  repeat_r;
    logic [14:0] invert_r;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // one index compare feeds both the write and the read path
    function automatic logic indexIs(input logic [2:0] addr,
                                     input logic [2:0] index);
        indexIs = (addr == index);
    endfunction

    // the three stop windows share one field position
    function automatic logic [DELAY_W-1:0] windowOf(input logic [31:0] word);
        windowOf = word[DELAY_HI:DELAY_LO];
    endfunction

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    wire logic hit2 = indexIs(regAddr, ADDR_INTERRUPT_EDGE_DELAY_ONE);
    wire logic hit3 = indexIs(regAddr, ADDR_TIMEOUT_DELAY_TWO);
    wire logic hit4 = indexIs(regAddr, ADDR_DELAY_THREE);
    wire logic hit5 = indexIs(regAddr, ADDR_FIRE_PULSE_CONFIG);

    // unmapped addresses read as zero
    wire logic [31:0] readMux = hit2 ? reg2_r :
                                hit3 ? reg3_r :
                                hit4 ? reg4_r :
                                hit5 ? reg5_r : 32'h0000_0000;

    // --------------------------------------------------------------
    // storage next values
    // --------------------------------------------------------------
    // hold until rewrite
    wire logic [31:0] reg2_nxt = (regWrite && hit2) ? regWdata : reg2_r;
    wire logic [31:0] reg3_nxt = (regWrite && hit3) ? regWdata : reg3_r;
    wire logic [31:0] reg4_nxt = (regWrite && hit4) ? regWdata : reg4_r;
    // bit 23 kept as written; host keeps it zero
    wire logic [31:0] reg5_nxt = (regWrite && hit5) ? regWdata : reg5_r;

    // tag bits read back verbatim
    // zero outside the answer cycle, so a stale word never lingers
    wire logic [31:0] regRdata_nxt = regRead ? readMux : 32'h0000_0000;

    // --------------------------------------------------------------
    // storage, one flip-flop bank per register
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg2_r <= RST_REG2;
        end else begin
            reg2_r <= reg2_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg3_r <= RST_REG3;
        end else begin
            reg3_r <= reg3_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg4_r <= RST_REG4;
        end else begin
            reg4_r <= reg4_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg5_r <= RST_REG5;
        end else begin
            reg5_r <= reg5_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdata_r <= 32'h0000_0000;
        end else begin
            regRdata_r <= regRdata_nxt;
        end
    end

    // --------------------------------------------------------------
    // field decode
    // --------------------------------------------------------------
    // enabled sources ORed
    wire logic irqOut_nxt = (reg2_r[INT_TIMEOUT_BIT] & irqTimeout)
                          | (reg2_r[INT_ENDHITS_BIT] & irqEndHits)
                          | (reg2_r[INT_ALU_BIT] & irqAlu)
                          | (memDoneIrqEn & irqMemDone);

    wire logic [1:0]  preSel    = reg3_r[PRESCALE_HI:PRESCALE_LO];
    wire logic [14:0] toCyc_nxt = (preSel == 2'h0) ? TIMEOUT_CYC_0 :
                                  (preSel == 2'h1) ? TIMEOUT_CYC_1 :
                                  (preSel == 2'h2) ? TIMEOUT_CYC_2 :
                                                     TIMEOUT_CYC_3;

    wire logic [31:0] fillVal_nxt = reg3_r[ERR_FILL_BIT] ? TIMEOUT_FILL_VALUE
                                                         : 32'h0000_0000;

    // windows pass as written; host zeroes them in digital mode
    wire logic [18:0] win1_nxt = windowOf(reg2_r);
    wire logic [18:0] win2_nxt = windowOf(reg3_r);
    wire logic [18:0] win3_nxt = windowOf(reg4_r);

    // pattern 011 is not guarded; host never writes it
    wire logic fireInv_nxt  = reg5_r[CFG_HI];
    wire logic fireUp_nxt   = reg5_r[CFG_HI-1];
    wire logic fireDown_nxt = reg5_r[CFG_LO];

    // --------------------------------------------------------------
    // interrupt output
    // --------------------------------------------------------------
    // sources share this clock, so one register is all the delay
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqOut_r <= 1'b0;
        end else begin
            irqOut_r <= irqOut_nxt;
        end
    end

    // --------------------------------------------------------------
    // stop path controls, one cycle behind the storage (analog select behind analogEnable)
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1Edge_r   <= RST_REG2[CH1_EDGE_BIT];
            ch2Edge_r   <= RST_REG2[CH2_EDGE_BIT];
            analogSel_r <= 1'b0;
            win1_r      <= RST_REG2[DELAY_HI:DELAY_LO];
            win2_r      <= RST_REG3[DELAY_HI:DELAY_LO];
            win3_r      <= RST_REG4[DELAY_HI:DELAY_LO];
        end else begin
            ch1Edge_r   <= reg2_r[CH1_EDGE_BIT];
            ch2Edge_r   <= reg2_r[CH2_EDGE_BIT];
            analogSel_r <= analogEnable;
            win1_r      <= win1_nxt;
            win2_r      <= win2_nxt;
            win3_r      <= win3_nxt;
        end
    end

    // --------------------------------------------------------------
    // timeout controls, one cycle behind the storage
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            errFill_r <= RST_REG3[ERR_FILL_BIT];
            fillVal_r <= 32'h0000_0000;
            toCyc_r   <= TIMEOUT_CYC_0;
        end else begin
            errFill_r <= reg3_r[ERR_FILL_BIT];
            fillVal_r <= fillVal_nxt;
            toCyc_r   <= toCyc_nxt;
        end
    end

    // --------------------------------------------------------------
    // fire generator controls, one cycle behind the storage
    // --------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fireInv_r  <= RST_REG5[CFG_HI];
            fireUp_r   <= RST_REG5[CFG_HI-1];
            fireDown_r <= RST_REG5[CFG_LO];
            startJit_r <= RST_REG5[START_JIT_BIT];
            phaseJit_r <= ~RST_REG5[PHASE_OFF_BIT];
            repeat_r   <= RST_REG5[REPEAT_HI:REPEAT_LO];
            invert_r   <= RST_REG5[INVERT_HI-1:INVERT_LO];
        end else begin
            fireInv_r  <= fireInv_nxt;
            fireUp_r   <= fireUp_nxt;
            fireDown_r <= fireDown_nxt;
            startJit_r <= reg5_r[START_JIT_BIT];
            phaseJit_r <= ~reg5_r[PHASE_OFF_BIT];
            repeat_r   <= reg5_r[REPEAT_HI:REPEAT_LO];
            // invert bits, bit 23 left out
            // bit 23 must stay zero, so it never reaches the generator
            invert_r   <= reg5_r[INVERT_HI-1:INVERT_LO];
        end
    end

    assign regRdata         = regRdata_r;
    assign irqOut           = irqOut_r;
    assign ch1BothEdges     = ch1Edge_r;
    assign ch2BothEdges     = ch2Edge_r;
    assign stopAnalogSel    = analogSel_r;
    assign stopWindowHit1   = win1_r;
    assign stopWindowHit2   = win2_r;
    assign stopWindowHit3   = win3_r;
    assign timeoutErrorFill = errFill_r;
    assign timeoutFillValue = fillVal_r;
    assign timeoutCycles    = toCyc_r;
    assign fireUpEnable     = fireUp_r;
    assign fireDownEnable   = fireDown_r;
    assign fireDownInvert   = fireInv_r;
    assign startJitterOn    = startJit_r;
    assign phaseJitterOn    = phaseJit_r;
    assign repeatCount      = repeat_r;
    assign perPulseInvert   = invert_r;

endmodule

// ===== verification/tcr_chk_properties.sv
`timescale 1ns/1ps
module tcr_chk (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic [2:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdata,
    input wire logic        irqTimeout,
    input wire logic        irqEndHits,
    input wire logic        irqAlu,
    input wire logic        irqMemDone,
    input wire logic        memDoneIrqEn,
    input wire logic        analogEnable,
    input wire logic        irqOut,
    input wire logic        ch1BothEdges,
    input wire logic        stopAnalogSel,
    input wire logic [18:0] stopWindowHit1,
    input wire logic        timeoutErrorFill,
    input wire logic [31:0] timeoutFillValue,
    input wire logic        fireDownInvert,
    input wire logic        fireUpEnable,
    input wire logic        fireDownEnable
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence s_wr2; regWrite && regAddr == 3'h2; endsequence
    sequence s_wr5; regWrite && regAddr == 3'h5; endsequence
    sequence s_idle; !(irqTimeout | irqEndHits | irqAlu | irqMemDone); endsequence
    property p_rd_quiet;
        !(regRead && regAddr inside {[3'h2:3'h5]}) |=> regRdata == 32'h0;
    endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray data");
    property p_quiet;
        s_idle |=> !irqOut;
    endproperty
    a_quiet: assert property (p_quiet) else $error("irq w/o source");
    property p_mem;
        irqMemDone && memDoneIrqEn |=> irqOut;
    endproperty
    a_mem: assert property (p_mem) else $error("memory irq lost");
    property p_ch1;
        s_wr2 |=> ##1 ch1BothEdges == $past(regWdata[27], 2);
    endproperty
    a_ch1: assert property (p_ch1) else $error("ch1 edge mode");
    property p_win1;
        s_wr2 |=> ##1 stopWindowHit1 == $past(regWdata[26:8], 2);
    endproperty
    a_win1: assert property (p_win1) else $error("hit1 window");
    property p_fill;
        timeoutFillValue == (timeoutErrorFill ? 32'h0FFF_FFFF : 32'h0);
    endproperty
    a_fill: assert property (p_fill) else $error("fill value");
    property p_cfg;
        s_wr5 |=> ##1 {fireDownInvert, fireUpEnable, fireDownEnable}
            == $past(regWdata[31:29], 2);
    endproperty
    a_cfg: assert property (p_cfg) else $error("fire output cfg");
    property p_analog;
        1'b1 |=> stopAnalogSel == $past(analogEnable);
    endproperty
    a_analog: assert property (p_analog) else $error("stop select");
endmodule
bind tcr_config_regs tcr_chk u_chk (.*);

// ===== verification/tcr_host_model.sv
`timescale 1ns/1ps
module tcr_host_model (
    input  wire logic        ref_clk,
    input  wire logic        analogOn,
    input  wire logic [31:0] regRdata,
    output logic      [2:0]  regAddr,
    output logic      [31:0] regWdata,
    output logic             regWrite,
    output logic             regRead
);
    initial {regAddr, regWdata, regWrite, regRead} = 37'h0;
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        if (!analogOn && a inside {[3'h2:3'h4]}) d[26:8] = 19'h0;
        if (a == 3'h5 && d[31:29] == 3'b011) d[31:29] = 3'b000;
        if (a == 3'h5) d[23] = 1'b0;
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
endmodule

// ===== verification/test_tcr_config_regs.sv
`timescale 1ns/1ps
module test_tcr_config_regs;
    import tcr_pkg::*;
    logic        ref_clk, reset_n, irqTimeout, irqEndHits, irqAlu, irqOut;
    logic        irqMemDone, memDoneIrqEn, analogEnable, regWrite, regRead;
    logic [2:0]  regAddr, repeatCount;
    logic [31:0] regWdata, regRdata, timeoutFillValue, rv, v;
    logic        ch1BothEdges, ch2BothEdges, stopAnalogSel, timeoutErrorFill;
    logic        fireUpEnable, fireDownEnable, fireDownInvert;
    logic        startJitterOn, phaseJitterOn;
    logic [18:0] stopWindowHit1, stopWindowHit2, stopWindowHit3;
    logic [14:0] timeoutCycles, perPulseInvert;
    int          n_errors, comparisons;
    tcr_config_regs uut (.*);
    tcr_host_model  host (.analogOn(analogEnable), .*);
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    task automatic conclude();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] e [4];
        e = '{RST_REG2, RST_REG3, RST_REG4, RST_REG5};
        for (int i = 0; i < 4; i++) begin
            host.rd(3'(i + 2), rv);
            chk("reset value", rv, e[i]);
        end
        chk("phase on", 32'(phaseJitterOn), 32'h1);
        chk("timeout", 32'(timeoutCycles), 32'h100);
    endtask
    task automatic t_regs();
        logic [31:0] w [4];
        w = '{32'h17FF_FF5A, 32'h0800_01C3, 32'h8000_2A3C, 32'hE4FF_FF11};
        host.wr(3'h2, w[0]);
        settle();
        chk("ch2 edges", 32'(ch2BothEdges), 32'h1);
        chk("win1 max", 32'(stopWindowHit1), 32'h7FFFF);
        host.wr(3'h2, w[1]);
        host.wr(3'h3, w[2]);
        host.wr(3'h4, w[3]);
        settle();
        chk("ch1 edges", 32'({ch2BothEdges, ch1BothEdges}), 32'h1);
        chk("win1", 32'(stopWindowHit1), 32'(w[1][26:8]));
        chk("win2", 32'(stopWindowHit2), 32'(w[2][26:8]));
        chk("win3", 32'(stopWindowHit3), 32'(w[3][26:8]));
        for (int i = 1; i < 4; i++) begin
            host.rd(3'(i + 1), rv);
            chk("readback", rv, w[i]);
        end
        host.wr(3'h6, 32'hFFFF_FFFF);
        host.rd(3'h6, rv);
        chk("unmapped", rv, 32'h0);
        host.rd(3'h4, rv);
        chk("kept", rv, w[3]);
    endtask
    task automatic t_prescale();
        for (int c = 0; c < 4; c++) begin
            host.wr(3'h3, {1'(c), 2'(c), 29'h0});
            settle();
            chk("cycles", 32'(timeoutCycles), (64 << (2 * c)) * 4);
            chk("fill", timeoutFillValue, c[0] ? 32'h0FFF_FFFF : 0);
            chk("fill on", 32'(timeoutErrorFill), 32'(c[0]));
        end
    endtask
    task automatic t_fire();
        for (int i = 0; i < 8; i++) begin
            v = {(i == 3) ? 3'b100 : 3'(i), i[0], i[1], 3'(i), 1'b0,
                 15'(16'h1 << (i * 2)), 8'(i)};
            host.wr(3'h5, v);
            settle();
            chk("cfg", 32'({fireDownInvert, fireUpEnable, fireDownEnable}),
                32'(v[31:29]));
            chk("start jit", 32'(startJitterOn), 32'(v[28]));
            chk("phase jit", 32'(phaseJitterOn), 32'(!v[27]));
            chk("repeat", 32'(repeatCount), 32'(i));
            chk("invert", 32'(perPulseInvert), 32'(v[22:8]));
        end
    endtask
    task automatic src(logic [3:0] s, logic en, logic exp);
        @(posedge ref_clk);
        {irqTimeout, irqEndHits, irqAlu, irqMemDone} <= s;
        memDoneIrqEn <= en;
        @(posedge ref_clk);
        #1;
        chk("irq", 32'(irqOut), 32'(exp));
    endtask
    task automatic t_irq();
        host.wr(3'h2, 32'hE000_0000);
        settle();
        for (int s = 1; s < 4; s++) begin
            src(4'(1 << s), 1'b0, 1'b1);
            src(4'h0, 1'b0, 1'b0);
        end
        src(4'h1, 1'b0, 1'b0);
        src(4'h1, 1'b1, 1'b1);
        host.wr(3'h2, 32'h4000_0000);
        settle();
        src(4'hA, 1'b0, 1'b0);
        src(4'h4, 1'b0, 1'b1);
        src(4'h0, 1'b0, 1'b0);
    endtask
    task automatic t_analog();
        @(posedge ref_clk);
        analogEnable <= 1'b0;
        settle();
        chk("digital", 32'(stopAnalogSel), 32'h0);
        host.wr(3'h2, 32'h07FF_FF00);
        settle();
        chk("zero win", 32'(stopWindowHit1), 32'h0);
        @(posedge ref_clk);
        analogEnable <= 1'b1;
        settle();
        chk("analog", 32'(stopAnalogSel), 32'h1);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end
    initial begin
        {reset_n, irqTimeout, irqEndHits, irqAlu, irqMemDone} = 5'h0;
        memDoneIrqEn = 1'b0;
        analogEnable = 1'b1;
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_regs();
        t_prescale();
        t_fire();
        t_irq();
        t_analog();
        conclude();
    end
endmodule
